// ### hdl/drs_pkg.sv
// Purpose: Shared constants and types for the memory device reset/init block
// Assumes: mclk at 250 MHz, memory pins sampled in the mclk domain
// Notes:   Command codes are {chip select, row, column, write} strobes, active low
package drs_pkg;

    // Timing
    localparam int CLK_MHZ       = 250;
    localparam int INIT_WAIT_US  = 500;
    localparam int INIT_WAIT_CYC = INIT_WAIT_US * CLK_MHZ;
    localparam int ZQ_INIT_TCK   = 512;

    // Widths
    localparam int ROW_W  = 14;
    localparam int COL_W  = 10;
    localparam int BANK_W = 3;
    localparam int BANK_N = 8;
    localparam int MR_N   = 4;

    // Address bit positions
    localparam int A_AUTO_PRE   = 10;
    localparam int A_CHOP_SEL   = 12;
    localparam int MR1_TERMINATION_STROBE_BIT = 11;
    localparam int MR1_RTT_B0   = 2;
    localparam int MR1_RTT_B1   = 6;
    localparam int MR1_RTT_B2   = 9;
    localparam int MR0_BT_BIT   = 3;
    localparam int MR0_BL_LO    = 0;

    // Burst length field codes and last pair index per burst length
    localparam logic [1:0] BL_FIXED8 = 2'h0;
    localparam logic [1:0] BL_OTF    = 2'h1;
    localparam logic [1:0] BL_FIXED4 = 2'h2;
    localparam logic [1:0] PAIRS_FULL = 2'h3;
    localparam logic [1:0] PAIRS_CHOP = 2'h1;

    // Commands
    localparam logic [3:0] CMD_MRS = 4'h0;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_WR  = 4'h4;
    localparam logic [3:0] CMD_RD  = 4'h5;
    localparam logic [3:0] CMD_ZQ  = 4'h6;

    typedef enum logic [2:0] {
        S_RESET, S_INIT, S_WAIT_CKE, S_CONFIG, S_CALIB, S_READY
    } drs_state_e;

    typedef struct packed {
        logic               clr_b;
        logic               ck;
        logic               cke;
        logic               termination_enable;
        logic               cs_b;
        logic               ras_b;
        logic               cas_b;
        logic               we_b;
        logic [BANK_W-1:0]  ba;
        logic [ROW_W-1:0]   a;
    } drs_pins_s;

endpackage : drs_pkg

// ### hdl/drs_order_if.sv
// Purpose: Carries burst start and beat pair to the order calculator
// Assumes: Combinational answer in the same cycle
// Notes:   seq side drives the request, calc side answers column low bits
`timescale 1ns/1ps
interface drs_order_if;
    logic [2:0] start;
    logic       interleave;
    logic       chop_write;
    logic [1:0] pair;
    logic [2:0] col_even;
    logic [2:0] col_odd;

    modport seq  (output start, interleave, chop_write, pair, input col_even, col_odd);
    modport calc (input start, interleave, chop_write, pair, output col_even, col_odd);
endinterface : drs_order_if

// ### hdl/drs_burst_order.sv
// Purpose: Column order of one word pair within a burst
// Assumes: Pair index 0..3, chopped reads use pairs 0..1 only
// Notes:   Chopped writes always start at the nibble base
`timescale 1ns/1ps
module drs_burst_order (
    // Order request and answer
    drs_order_if.calc o
);
    logic [2:0] base;
    logic [2:0] ev;
    logic [2:0] od;

    assign base = o.chop_write ? {o.start[2], 2'h0} : o.start;
    assign ev   = {o.pair, 1'b0};
    assign od   = {o.pair, 1'b1};

    // Sequential wraps within the nibble, interleaved is an xor
    assign o.col_even = o.interleave ? (base ^ ev)
                                     : {base[2] ^ ev[2], 2'(base[1:0] + ev[1:0])};
    assign o.col_odd  = o.interleave ? (base ^ od)
                                     : {base[2] ^ od[2], 2'(base[1:0] + od[1:0])};
endmodule : drs_burst_order

// ### hdl/drs_device.sv
// Purpose: Device side reset, init, mode registers and burst framing
// Assumes: Memory pins and clock come from outside and are synchronised here
// Notes:   Command capture waits for the sampled rising edge of the memory clock
//
// Operation
// - Device initialises internally after clear release without needing the memory clock.
// - Termination stays off during clear and until clock gate registers high.
// - Bursts are eight words or chopped four, two words per clock, ordered.
// - Activate picks bank and row, then read or write follows.
// - Read/write address gives column, auto precharge flag and chop select flag.
// - Mode one bit 11 selects strobe termination or write byte mask.
// - Mode write bank bits pick the register, address carries contents.
`timescale 1ns/1ps
module drs_device #(
    parameter int INIT_CYC = drs_pkg::INIT_WAIT_CYC,
    parameter int ZQ_TCK   = drs_pkg::ZQ_INIT_TCK
) (
    // System
    input  wire logic                          mclk,
    input  wire logic                          rst_b,
    // Memory pins
    input  wire logic                          pin_clear_b,
    input  wire logic                          pin_ck,
    input  wire logic                          pin_cke,
    input  wire logic                          pin_termination_enable,
    input  wire logic                          pin_cs_b,
    input  wire logic                          pin_ras_b,
    input  wire logic                          pin_cas_b,
    input  wire logic                          pin_we_b,
    input  wire logic [drs_pkg::BANK_W-1:0]    pin_bank_select_bits,
    input  wire logic [drs_pkg::ROW_W-1:0]     pin_addr,
    // Status
    output logic                               init_busy,
    output logic                               calib_busy,
    output logic                               dev_ready,
    output logic                               term_active,
    output logic                               termination_strobe_term_en,
    output logic                               write_mask_en,
    output logic                               cmd_reject,
    // Burst words
    output logic                               burst_valid,
    output logic                               burst_write,
    output logic                               burst_last,
    output logic                               burst_auto_pre,
    output logic [drs_pkg::BANK_W-1:0]         burst_bank,
    output logic [drs_pkg::ROW_W-1:0]          burst_row,
    output logic [drs_pkg::COL_W-1:0]          burst_col_even,
    output logic [drs_pkg::COL_W-1:0]          burst_col_odd
);
    import drs_pkg::*;

    localparam int CW = $clog2(((INIT_CYC > ZQ_TCK) ? INIT_CYC : ZQ_TCK) + 1);

    typedef struct packed {
        drs_pins_s                     s1;
        drs_pins_s                     s2;
        logic                          ck_prev;
        drs_state_e                    st;
        logic [CW-1:0]                 cnt;
        logic                          cke_reg;
        logic                          term_on;
        logic [MR_N-1:0][ROW_W-1:0]    mr;
        logic [BANK_N-1:0]             open;
        logic [BANK_N-1:0][ROW_W-1:0]  row;
        logic                          busy;
        logic                          wr;
        logic                          chop;
        logic                          ap;
        logic                          bt;
        logic [BANK_W-1:0]             bank;
        logic [ROW_W-1:0]              brow;
        logic [COL_W-1:0]              col;
        logic [1:0]                    pair;
        logic [1:0]                    last_pair;
        logic                          o_init;
        logic                          o_calib;
        logic                          o_ready;
        logic                          o_termination_strobe;
        logic                          o_mask;
        logic                          o_rej;
        logic                          o_valid;
        logic                          o_last;
        logic [COL_W-1:0]              o_ceven;
        logic [COL_W-1:0]              o_codd;
    } drs_dev_s;

    drs_dev_s q;
    drs_dev_s nxt;

    drs_order_if ord ();

    logic       ck_rise;
    logic [3:0] cmd;
    logic       cmd_ok;
    logic       mrs_now;
    logic       act_now;
    logic       rw_now;
    logic       zq_now;
    logic       chop_now;
    logic       last_now;
    logic       start_now;
    logic       rtt_on;

    ////////////////////////////////////////////////////////////////////////////
    // Command decode on the sampled memory clock edge
    assign ck_rise  = q.s2.ck & ~q.ck_prev;
    assign cmd      = {q.s2.cs_b, q.s2.ras_b, q.s2.cas_b, q.s2.we_b};
    assign cmd_ok   = ck_rise & q.s2.clr_b & q.cke_reg;
    assign mrs_now  = cmd_ok & (cmd == CMD_MRS) & ~q.s2.ba[2]
                      & ((q.st == S_CONFIG) | (q.st == S_READY));
    assign act_now  = cmd_ok & (cmd == CMD_ACT) & (q.st == S_READY);
    assign rw_now   = cmd_ok & ((cmd == CMD_RD) | (cmd == CMD_WR)) & (q.st == S_READY);
    assign zq_now   = cmd_ok & (cmd == CMD_ZQ) & q.s2.a[A_AUTO_PRE]
                      & ((q.st == S_CONFIG) | (q.st == S_READY));
    // Chop select low means chopped, only honoured in on-the-fly mode
    assign chop_now = (q.mr[0][MR0_BL_LO +: 2] == BL_FIXED4)
                      | ((q.mr[0][MR0_BL_LO +: 2] == BL_OTF) & ~q.s2.a[A_CHOP_SEL]);
    assign last_now = q.busy & ck_rise & (q.pair == q.last_pair);
    assign start_now = rw_now & q.open[q.s2.ba] & (~q.busy | last_now);
    assign rtt_on   = q.mr[1][MR1_RTT_B0] | q.mr[1][MR1_RTT_B1] | q.mr[1][MR1_RTT_B2];

    assign ord.start      = q.col[2:0];
    assign ord.interleave = q.bt;
    assign ord.chop_write = q.chop & q.wr;
    assign ord.pair       = q.pair;

    drs_burst_order u_order (
        .o (ord.calc)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        nxt         = q;
        nxt.s1      = {pin_clear_b, pin_ck, pin_cke, pin_termination_enable, pin_cs_b,
                       pin_ras_b, pin_cas_b, pin_we_b, pin_bank_select_bits, pin_addr};
        nxt.s2      = q.s1;
        nxt.ck_prev = q.s2.ck;
        nxt.o_rej   = 1'b0;
        nxt.o_valid = 1'b0;
        nxt.o_last  = 1'b0;

        case (q.st)
            S_RESET: begin
                nxt.st  = S_INIT;
                nxt.cnt = CW'(INIT_CYC - 1);
            end
            // Counted on mclk so a stopped memory clock cannot stall it
            S_INIT: begin
                if (q.cnt == '0) begin
                    nxt.st = S_WAIT_CKE;
                end else begin
                    nxt.cnt = q.cnt - CW'(1);
                end
            end
            S_WAIT_CKE: begin
                if (ck_rise && q.s2.cke) begin
                    nxt.cke_reg = 1'b1;
                    nxt.st      = S_CONFIG;
                end
            end
            S_CONFIG: begin
                if (zq_now) begin
                    nxt.st  = S_CALIB;
                    nxt.cnt = CW'(ZQ_TCK - 1);
                end
            end
            S_CALIB: begin
                if (ck_rise) begin
                    if (q.cnt == '0) begin
                        nxt.st = S_READY;
                    end else begin
                        nxt.cnt = q.cnt - CW'(1);
                    end
                end
            end
            S_READY: begin
                if (zq_now) begin
                    nxt.st  = S_CALIB;
                    nxt.cnt = CW'(ZQ_TCK - 1);
                end
            end
            default: begin
                nxt.st = S_RESET;
            end
        endcase

        if (mrs_now) begin
            nxt.mr[q.s2.ba[1:0]] = q.s2.a;
        end
        if (act_now) begin
            nxt.open[q.s2.ba] = 1'b1;
            nxt.row[q.s2.ba]  = q.s2.a;
        end

        // One word pair per memory clock, first pair on the edge after the command
        if (q.busy && ck_rise) begin
            nxt.o_valid = 1'b1;
            nxt.o_last  = last_now;
            nxt.o_ceven = {q.col[COL_W-1:3], ord.col_even};
            nxt.o_codd  = {q.col[COL_W-1:3], ord.col_odd};
            nxt.pair    = q.pair + 2'h1;
            if (last_now) begin
                nxt.busy = 1'b0;
                // An activate to the same bank in this cycle wins over the close
                if (q.ap && !(act_now && (q.s2.ba == q.bank))) begin
                    nxt.open[q.bank] = 1'b0;
                end
            end
        end
        if (start_now) begin
            nxt.busy      = 1'b1;
            nxt.wr        = (cmd == CMD_WR);
            nxt.chop      = chop_now;
            nxt.ap        = q.s2.a[A_AUTO_PRE];
            nxt.bt        = q.mr[0][MR0_BT_BIT];
            nxt.bank      = q.s2.ba;
            nxt.brow      = q.row[q.s2.ba];
            nxt.col       = q.s2.a[COL_W-1:0];
            nxt.pair      = 2'h0;
            nxt.last_pair = chop_now ? PAIRS_CHOP : PAIRS_FULL;
        end else if (rw_now) begin
            // No open row, or previous burst still running
            nxt.o_rej = 1'b1;
        end

        // Termination follows the pin only once clock gate has registered high
        if (!q.cke_reg) begin
            nxt.term_on = 1'b0;
        end else if (ck_rise) begin
            nxt.term_on = q.s2.termination_enable & rtt_on;
        end

        // Chip clear wins over everything, mode contents are kept
        if (!q.s2.clr_b) begin
            nxt.st      = S_RESET;
            nxt.cke_reg = 1'b0;
            nxt.term_on = 1'b0;
            nxt.open    = '0;
            nxt.busy    = 1'b0;
            nxt.o_valid = 1'b0;
            nxt.o_rej   = 1'b0;
        end

        nxt.o_init  = (nxt.st == S_RESET) | (nxt.st == S_INIT);
        nxt.o_calib = (nxt.st == S_CALIB);
        nxt.o_ready = (nxt.st == S_READY);
        nxt.o_termination_strobe  = nxt.mr[1][MR1_TERMINATION_STROBE_BIT];
        nxt.o_mask  = ~nxt.mr[1][MR1_TERMINATION_STROBE_BIT];
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign init_busy      = q.o_init;
    assign calib_busy     = q.o_calib;
    assign dev_ready      = q.o_ready;
    assign term_active    = q.term_on;
    assign termination_strobe_term_en   = q.o_termination_strobe;
    assign write_mask_en  = q.o_mask;
    assign cmd_reject     = q.o_rej;
    assign burst_valid    = q.o_valid;
    assign burst_write    = q.wr;
    assign burst_last     = q.o_last;
    assign burst_auto_pre = q.ap;
    assign burst_bank     = q.bank;
    assign burst_row      = q.brow;
    assign burst_col_even = q.o_ceven;
    assign burst_col_odd  = q.o_codd;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_term_off_clear: assert property (!q.s2.clr_b |=> !term_active)
        else $error("termination on while chip clear held");
    a_term_off_cke: assert property (!q.cke_reg |=> !term_active)
        else $error("termination on before clock gate registered");
    a_init_count: assert property ((q.st == S_INIT) && (q.cnt != '0) && q.s2.clr_b
        |=> q.cnt == ($past(q.cnt) - CW'(1)))
        else $error("internal init count stalled");
    a_mode_write: assert property (mrs_now |=> q.mr[$past(q.s2.ba[1:0])] == $past(q.s2.a))
        else $error("mode register not loaded");
    a_strobe_mode: assert property (1'b1 |=> (termination_strobe_term_en == q.mr[1][MR1_TERMINATION_STROBE_BIT])
        && (write_mask_en != termination_strobe_term_en))
        else $error("strobe pin function wrong");
    a_act_row: assert property (act_now |=> q.open[$past(q.s2.ba)]
        && (q.row[$past(q.s2.ba)] == $past(q.s2.a)))
        else $error("activate did not open row");
    a_rw_closed: assert property (rw_now && !q.open[q.s2.ba] && q.s2.clr_b |=> cmd_reject)
        else $error("access to closed bank not rejected");
    a_burst_len: assert property (start_now && q.s2.clr_b
        |=> q.last_pair == ($past(chop_now) ? PAIRS_CHOP : PAIRS_FULL))
        else $error("burst length wrong");
    a_pair_order: assert property (burst_valid |-> (burst_col_odd[2] == burst_col_even[2])
        && ((burst_col_odd[1:0] == 2'(burst_col_even[1:0] + 2'h1))
        || (burst_col_odd[1:0] == (burst_col_even[1:0] ^ 2'h1))))
        else $error("word pair out of order");
    a_auto_pre: assert property (burst_valid && burst_last && burst_auto_pre && !act_now
        |-> !q.open[burst_bank])
        else $error("auto precharge left bank open");

    c_ready: cover property (q.st == S_CALIB ##1 q.st == S_READY);
    c_mode:  cover property (mrs_now);
    c_chop:  cover property (start_now && chop_now);
    c_full:  cover property (burst_valid && burst_last && !q.chop);
endmodule : drs_device

// ### testbench/drs_ctrl_model.sv
// Purpose: Controller model that drives the memory pins of the device
// Assumes: Memory clock is mclk divided by 16, every pin edge 1 ns after mclk rises
// Notes:   Released bank and address lines show the inverse of their last value
`timescale 1ns/1ps
module drs_ctrl_model #(
    parameter int WAIT_CYC = 60
) (
    // Clock
    input  wire logic          mclk,
    // Memory pins
    output drs_pkg::drs_pins_s pins
);
    import drs_pkg::*;

    logic       ck_run;
    logic [2:0] div;

    initial begin
        ck_run = 1'b0;
        div    = 3'h0;
        pins   = '{clr_b: 1'b0, ck: 1'b0, cke: 1'b0, termination_enable: 1'b1, cs_b: 1'b1, ras_b: 1'b1,
                   cas_b: 1'b1, we_b: 1'b1, ba: 3'h5, a: 14'h2aaa};
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Memory clock stands still until the clock start step
    always begin
        @(posedge mclk);
        #1;
        if (ck_run) begin
            div = div + 3'h1;
            if (div == 3'h0) begin
                pins.ck = ~pins.ck;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic mclks(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : mclks

    // Held from the falling memory clock edge over the next rising one
    task automatic drive(input logic [3:0] c, input logic [2:0] ba, input logic [13:0] a);
        @(negedge pins.ck);
        {pins.cs_b, pins.ras_b, pins.cas_b, pins.we_b} = c;
        pins.ba = ba;
        pins.a  = a;
        @(posedge pins.ck);
    endtask : drive

    task automatic idle(input int n);
        @(negedge pins.ck);
        // Alternate deselect and no-operation so both idle forms are seen
        pins.cs_b = ~pins.cs_b;
        {pins.ras_b, pins.cas_b, pins.we_b} = 3'h7;
        pins.ba = ~pins.ba;
        pins.a  = ~pins.a;
        repeat (n) @(posedge pins.ck);
    endtask : idle

    task automatic set_term(input logic v);
        @(negedge pins.ck);
        pins.termination_enable = v;
    endtask : set_term

    task automatic power_up(input int hold, input logic [13:0] mr1, input logic [13:0] mr0);
        ck_run     = 1'b0;
        pins.cke   = 1'b0;
        pins.clr_b = 1'b0;
        mclks(hold);
        pins.clr_b = 1'b1;
        mclks(WAIT_CYC);
        ck_run = 1'b1;
        idle(6);
        @(negedge pins.ck);
        pins.cke = pins.clr_b;
        pins.termination_enable = 1'b0;
        idle(6);
        drive(CMD_MRS, 3'h2, 14'h0000);
        idle(1);
        drive(CMD_MRS, 3'h3, 14'h0000);
        idle(1);
        drive(CMD_MRS, 3'h1, mr1);
        idle(1);
        drive(CMD_MRS, 3'h0, mr0);
        idle(1);
        drive(CMD_ZQ, 3'h0, 14'h0400);
        idle(1);
    endtask : power_up
endmodule : drs_ctrl_model

// ### testbench/tb.sv
// Purpose: Self-checking bench for the device reset, init and burst framing
// Assumes: Shortened init and calibration counts, memory clock 64 ns
// Notes:   Burst cases sit in a table, resets and refusals are written out
`timescale 1ns/1ps
module tb;
    import drs_pkg::*;

    typedef struct packed {
        logic        wr;
        logic        chop;
        logic        il;
        logic        ap;
        logic [2:0]  start;
        logic [31:0] beats;
    } drs_row_s;

    localparam logic [13:0] MR1_INIT = 14'h0804;
    localparam logic [13:0] MR0_INIT = 14'h0101;

    logic        mclk;
    logic        rst_b;
    drs_pins_s   pins;
    logic        init_busy, calib_busy, dev_ready, term_active;
    logic        termination_strobe_term_en, write_mask_en, cmd_reject;
    logic        burst_valid, burst_write, burst_last, burst_auto_pre;
    logic [2:0]  burst_bank;
    logic [13:0] burst_row;
    logic [9:0]  burst_col_even, burst_col_odd;
    int          errors;
    int          n_compared;
    int          rejects;
    drs_row_s    rows [6];
    drs_row_s    r;

    drs_ctrl_model #(.WAIT_CYC(60)) drs_ctrl_model_inst (.mclk(mclk), .pins(pins));

    drs_device #(.INIT_CYC(40), .ZQ_TCK(4)) drs_device_inst (
        .mclk(mclk), .rst_b(rst_b), .pin_clear_b(pins.clr_b), .pin_ck(pins.ck),
        .pin_cke(pins.cke), .pin_termination_enable(pins.termination_enable), .pin_cs_b(pins.cs_b),
        .pin_ras_b(pins.ras_b), .pin_cas_b(pins.cas_b), .pin_we_b(pins.we_b),
        .pin_bank_select_bits(pins.ba), .pin_addr(pins.a), .init_busy(init_busy),
        .calib_busy(calib_busy), .dev_ready(dev_ready), .term_active(term_active),
        .termination_strobe_term_en(termination_strobe_term_en), .write_mask_en(write_mask_en), .cmd_reject(cmd_reject),
        .burst_valid(burst_valid), .burst_write(burst_write), .burst_last(burst_last),
        .burst_auto_pre(burst_auto_pre), .burst_bank(burst_bank), .burst_row(burst_row),
        .burst_col_even(burst_col_even), .burst_col_odd(burst_col_odd));

    always #2 mclk = ~mclk;

    // Pulses are counted at the falling edge, where they have settled
    always @(negedge mclk) begin
        if (cmd_reject === 1'b1) begin
            rejects++;
        end
    end

    // Bounds the edge waits inside the pin model
    initial begin
        repeat (50000) @(posedge mclk);
        errors++;
        $display("[ERR] %0t run limit reached", $time);
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    // Bounded wait on ready (0) or a pair strobe (1)
    task automatic wait_sig(input int which, input int lim);
        int k;
        k = 0;
        do begin
            @(negedge mclk);
            k++;
        end while ((which == 0 ? dev_ready : burst_valid) !== 1'b1 && k < lim);
        if ((which == 0 ? dev_ready : burst_valid) !== 1'b1) begin
            errors++;
            $display("[ERR] %0t wait ran out", $time);
            conclude();
        end
    endtask : wait_sig

    task automatic check_burst(input drs_row_s c, input logic [2:0] bank);
        int n;
        n = c.chop ? 2 : 4;
        for (int p = 0; p < n; p++) begin
            wait_sig(1, 40);
            check({burst_col_even, burst_col_odd},
                  {12'h0, 7'h2b, c.beats[30-8*p -: 3], 7'h2b, c.beats[26-8*p -: 3]});
            check(burst_last, p == n - 1);
            if (p == 0) begin
                check({burst_write, burst_auto_pre, burst_bank, burst_row},
                      {c.wr, c.ap, bank, 14'h1230 + 14'(bank)});
            end
        end
    endtask : check_burst

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        errors     = 0;
        n_compared = 0;
        rejects    = 0;
        mclk       = 1'b0;
        rst_b      = 1'b0;
        // Write, chop, interleave, auto precharge, start column, beat order
        rows[0] = '{1'b0, 1'b0, 1'b0, 1'b0, 3'h1, 32'h12305674};
        rows[1] = '{1'b0, 1'b0, 1'b1, 1'b0, 3'h3, 32'h32107654};
        rows[2] = '{1'b0, 1'b1, 1'b0, 1'b0, 3'h5, 32'h56740000};
        rows[3] = '{1'b1, 1'b1, 1'b0, 1'b0, 3'h6, 32'h45670000};
        rows[4] = '{1'b1, 1'b0, 1'b0, 1'b0, 3'h2, 32'h23016745};
        rows[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 3'h5, 32'h54761032};
        repeat (3) @(posedge mclk);
        #1;
        check({init_busy, calib_busy, dev_ready, term_active, burst_valid, cmd_reject}, 32'h0);
        repeat (3) @(posedge mclk);
        #1;
        rst_b = 1'b1;
        fork
            drs_ctrl_model_inst.power_up(60, MR1_INIT, MR0_INIT);
            begin
                repeat (20) @(negedge mclk);
                check({init_busy, term_active, dev_ready}, 32'h4);
                repeat (95) @(negedge mclk);
                check({init_busy, term_active, dev_ready}, 32'h0);
            end
        join
        @(negedge mclk);
        check({calib_busy, dev_ready}, 32'h2);
        wait_sig(0, 200);
        check({init_busy, calib_busy, termination_strobe_term_en, write_mask_en}, 32'h2);
        for (int i = 0; i < 6; i++) begin
            r = rows[i];
            drs_ctrl_model_inst.drive(CMD_MRS, 3'h0, 14'h0100 | {10'h0, r.il, 1'b0, BL_OTF});
            drs_ctrl_model_inst.idle(1);
            drs_ctrl_model_inst.drive(CMD_ACT, i[2:0], 14'h1230 + 14'(i));
            drs_ctrl_model_inst.drive(r.wr ? CMD_WR : CMD_RD, i[2:0],
                                      {1'b0, ~r.chop, 1'b0, r.ap, 7'h2b, r.start});
            fork
                drs_ctrl_model_inst.idle(8);
                check_burst(r, i[2:0]);
            join
        end
        check(rejects, 0);
        // Bank 5 closed by auto precharge, bank 7 never opened
        drs_ctrl_model_inst.drive(CMD_RD, 3'h5, 14'h1000);
        drs_ctrl_model_inst.drive(CMD_WR, 3'h7, 14'h1000);
        drs_ctrl_model_inst.drive(CMD_MRS, 3'h1, 14'h0004);
        drs_ctrl_model_inst.set_term(1'b1);
        drs_ctrl_model_inst.idle(3);
        check(rejects, 2);
        check({termination_strobe_term_en, write_mask_en, term_active}, 32'h3);
        // Reset with stable power while termination is requested
        fork
            drs_ctrl_model_inst.power_up(25, MR1_INIT, MR0_INIT);
            begin
                repeat (10) @(negedge mclk);
                check({init_busy, dev_ready, term_active}, 32'h4);
            end
        join
        wait_sig(0, 200);
        check({dev_ready, termination_strobe_term_en, write_mask_en}, 32'h6);
        conclude();
    end
endmodule : tb
